// ===== pkg/cit_timing_defs.vh
// Byte lengths and cycle counts for the instruction timing unit.
`ifndef CIT_TIMING_DEFS_VH
`define CIT_TIMING_DEFS_VH

// Each timing constant packs {byte length[1:0], cycle count[2:0]}.
`define CIT_LEN_MSB        4
`define CIT_LEN_LSB        3
`define CIT_CYC_MSB        2
`define CIT_CYC_LSB        0

// Accumulator loads.
`define CIT_T_MOV_A_RN     {2'h1, 3'h1}
`define CIT_T_MOV_A_DIR    {2'h2, 3'h2}
`define CIT_T_MOV_A_IND    {2'h1, 3'h2}
`define CIT_T_MOV_A_IMM    {2'h2, 3'h2}

// Working register loads.
`define CIT_T_MOV_RN_A     {2'h1, 3'h2}
`define CIT_T_MOV_RN_DIR   {2'h2, 3'h4}
`define CIT_T_MOV_RN_IMM   {2'h2, 3'h2}

// Direct address stores.
`define CIT_T_MOV_DIR_A    {2'h2, 3'h3}
`define CIT_T_MOV_DIR_RN   {2'h2, 3'h3}
`define CIT_T_MOV_DIR_DIR  {2'h3, 3'h4}
`define CIT_T_MOV_DIR_IND  {2'h2, 3'h4}
`define CIT_T_MOV_DIR_IMM  {2'h3, 3'h3}

// Indirect RAM stores.
`define CIT_T_MOV_IND_A    {2'h1, 3'h3}
`define CIT_T_MOV_IND_DIR  {2'h2, 3'h3}
`define CIT_T_MOV_IND_IMM  {2'h2, 3'h3}

// Data pointer load and code memory reads.
`define CIT_T_MOV_DPTR     {2'h3, 3'h3}
`define CIT_T_MOVC         {2'h1, 3'h4}

// Stack.
`define CIT_T_PUSH         {2'h2, 3'h4}
`define CIT_T_POP          {2'h2, 3'h3}

// Exchanges.
`define CIT_T_XCH_RN       {2'h1, 3'h3}
`define CIT_T_XCH_DIR      {2'h2, 3'h4}
`define CIT_T_XCH_IND      {2'h1, 3'h4}
`define CIT_T_XCHD         {2'h1, 3'h4}

// Arithmetic and logic with the accumulator as destination.
`define CIT_T_ALU_RN       {2'h1, 3'h2}
`define CIT_T_ALU_DIR      {2'h2, 3'h3}
`define CIT_T_ALU_IND      {2'h1, 3'h3}
`define CIT_T_ALU_IMM      {2'h2, 3'h2}

// Logic with a direct byte as destination.
`define CIT_T_LOG_DIR_A    {2'h2, 3'h4}
`define CIT_T_LOG_DIR_IMM  {2'h3, 3'h4}

// Increment, decrement, multiply, divide and decimal adjust.
`define CIT_T_INC_A        {2'h1, 3'h2}
`define CIT_T_INC_RN       {2'h1, 3'h3}
`define CIT_T_INC_DIR      {2'h2, 3'h4}
`define CIT_T_INC_IND      {2'h1, 3'h4}
`define CIT_T_INC_DPTR     {2'h1, 3'h1}
`define CIT_T_MUL          {2'h1, 3'h4}
`define CIT_T_DIV          {2'h1, 3'h5}
`define CIT_T_DA           {2'h1, 3'h4}

// Single byte accumulator and carry operations.
`define CIT_T_ROT          {2'h1, 3'h1}
`define CIT_T_CLR_A        {2'h1, 3'h1}
`define CIT_T_CPL_A        {2'h1, 3'h2}
`define CIT_T_CARRY        {2'h1, 3'h1}

// Direct bit operations.
`define CIT_T_BIT_LOGIC    {2'h2, 3'h3}
`define CIT_T_BIT_TO_C     {2'h2, 3'h3}
`define CIT_T_C_TO_BIT     {2'h2, 3'h4}
`define CIT_T_BIT_WRITE    {2'h2, 3'h4}

// Unknown or out of scope opcodes are sequenced as one byte, one cycle.
`define CIT_T_UNKNOWN      {2'h1, 3'h1}

`endif

// ===== rtl/cit_cycle_ctr.v
// Saturating cycle counter that tracks cycles spent on one instruction.
`timescale 1ns/100ps
`include "cit_timing_defs.vh"

module cit_cycle_ctr #(
   parameter W = 3                          // Counter width.
) (
   input  wire         clk,                 // System clock.
   input  wire         rst_n,               // Asynchronous reset, active low.
   input  wire         start,               // Loads one: first cycle is consumed.
   input  wire         step,                // Counts one more cycle.
   output reg  [W-1:0] count                // Cycles consumed so far.
);

   localparam [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};
   localparam [W-1:0] TOP = {W{1'b1}};

   // Start wins over step; the count holds at its top value when stalled.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= {W{1'b0}};
      end else if (start) begin
         count <= ONE;
      end else if (step && (count != TOP)) begin
         count <= count + ONE;
      end
   end

endmodule // cit_cycle_ctr

// ===== rtl/cit_timing_core.v
// Instruction fetch sequencer that applies per-instruction lengths and cycle counts.
`timescale 1ns/100ps
`include "cit_timing_defs.vh"

module cit_timing_core #(
   parameter CYC_W = 3                      // Width of the cycle counter.
) (
   input  wire         clk,                 // System clock, 125 MHz.
   input  wire         rst_n,               // Asynchronous reset, active low.
   input  wire  [7:0]  code_byte,           // Byte from program memory.
   input  wire         code_valid,          // Program memory byte is present.
   output reg          code_req,            // Ready to take a code byte.
   output reg          busy,                // Instruction in progress.
   output reg          ins_done,            // One-cycle pulse at completion.
   output reg   [7:0]  ins_opcode,          // Opcode of completed instruction.
   output reg   [7:0]  ins_op1,             // First operand byte.
   output reg   [7:0]  ins_op2,             // Second operand byte.
   output reg   [1:0]  ins_len,             // Bytes fetched for it.
   output reg   [2:0]  ins_cyc,             // Cycle count from its timing.
   output reg          ins_known            // Opcode had a known timing.
);

   localparam       ST_FETCH = 1'b0;
   localparam       ST_EXEC  = 1'b1;
   localparam [1:0] LEN_ONE  = 2'h1;
   localparam [2:0] CYC_ONE  = 3'h1;

   // Low nibble classes shared by the regular opcode rows.
   localparam [1:0] LC_OTHER = 2'h0;
   localparam [1:0] LC_IND   = 2'h1;
   localparam [1:0] LC_REG   = 2'h2;

   // Classifies the low nibble: 8..F register, 6..7 indirect.
   function [1:0] cit_low_class;
      input [3:0] lo;
      begin
         if (lo[3])
            cit_low_class = LC_REG;
         else if (lo[3:1] == 3'h3)
            cit_low_class = LC_IND;
         else
            cit_low_class = LC_OTHER;
      end
   endfunction

   // Timing of the accumulator-destination arithmetic and logic rows.
   function [4:0] cit_alu_row;
      input [3:0] lo;
      begin
         case (cit_low_class(lo))
            LC_REG:  cit_alu_row = `CIT_T_ALU_RN;
            LC_IND:  cit_alu_row = `CIT_T_ALU_IND;
            default: cit_alu_row = (lo == 4'h5) ? `CIT_T_ALU_DIR : `CIT_T_ALU_IMM;
         endcase
      end
   endfunction

   // Returns {known, length, cycles} for one opcode.
   function [5:0] cit_decode;
      input [7:0] op;
      reg   [4:0] t;
      reg         k;
      reg   [1:0] lc;
      begin
         t  = `CIT_T_UNKNOWN;
         k  = 1'b1;
         lc = cit_low_class(op[3:0]);
         case (op[7:4])
            // Increment and decrement rows, plus the plain rotates.
            4'h0, 4'h1: begin
               if (lc == LC_REG)
                  t = `CIT_T_INC_RN;
               else if (lc == LC_IND)
                  t = `CIT_T_INC_IND;
               else if (op[3:0] == 4'h3)
                  t = `CIT_T_ROT;
               else if (op[3:0] == 4'h4)
                  t = `CIT_T_INC_A;
               else if (op[3:0] == 4'h5)
                  t = `CIT_T_INC_DIR;
               else
                  k = 1'b0;
            end
            // Add and add-with-carry rows, plus the carry rotates.
            4'h2, 4'h3: begin
               if (op[3:0] == 4'h3)
                  t = `CIT_T_ROT;
               else if (op[3:2] != 2'h0)
                  t = cit_alu_row(op[3:0]);
               else
                  k = 1'b0;
            end
            // OR, AND and XOR rows share a layout.
            4'h4, 4'h5, 4'h6: begin
               if (op[3:0] == 4'h2)
                  t = `CIT_T_LOG_DIR_A;
               else if (op[3:0] == 4'h3)
                  t = `CIT_T_LOG_DIR_IMM;
               else if (op[3:2] != 2'h0)
                  t = cit_alu_row(op[3:0]);
               else
                  k = 1'b0;
            end
            // Immediate moves and OR of carry with a direct bit.
            4'h7: begin
               if (lc == LC_REG)
                  t = `CIT_T_MOV_RN_IMM;
               else if (lc == LC_IND)
                  t = `CIT_T_MOV_IND_IMM;
               else if (op[3:0] == 4'h2)
                  t = `CIT_T_BIT_LOGIC;
               else if (op[3:0] == 4'h4)
                  t = `CIT_T_MOV_A_IMM;
               else if (op[3:0] == 4'h5)
                  t = `CIT_T_MOV_DIR_IMM;
               else
                  k = 1'b0;
            end
            // Direct destination moves, divide, code read, carry AND.
            4'h8: begin
               if (lc == LC_REG)
                  t = `CIT_T_MOV_DIR_RN;
               else if (lc == LC_IND)
                  t = `CIT_T_MOV_DIR_IND;
               else if (op[3:0] == 4'h2)
                  t = `CIT_T_BIT_LOGIC;
               else if (op[3:0] == 4'h3)
                  t = `CIT_T_MOVC;
               else if (op[3:0] == 4'h4)
                  t = `CIT_T_DIV;
               else if (op[3:0] == 4'h5)
                  t = `CIT_T_MOV_DIR_DIR;
               else
                  k = 1'b0;
            end
            // Data pointer load, carry to bit, code read, subtract.
            4'h9: begin
               if (op[3:0] == 4'h0)
                  t = `CIT_T_MOV_DPTR;
               else if (op[3:0] == 4'h2)
                  t = `CIT_T_C_TO_BIT;
               else if (op[3:0] == 4'h3)
                  t = `CIT_T_MOVC;
               else if (op[3:2] != 2'h0)
                  t = cit_alu_row(op[3:0]);
               else
                  k = 1'b0;
            end
            // Direct to register moves, bit to carry, multiply.
            4'hA: begin
               if (lc == LC_REG)
                  t = `CIT_T_MOV_RN_DIR;
               else if (lc == LC_IND)
                  t = `CIT_T_MOV_IND_DIR;
               else if (op[3:0] == 4'h0)
                  t = `CIT_T_BIT_LOGIC;
               else if (op[3:0] == 4'h2)
                  t = `CIT_T_BIT_TO_C;
               else if (op[3:0] == 4'h3)
                  t = `CIT_T_INC_DPTR;
               else if (op[3:0] == 4'h4)
                  t = `CIT_T_MUL;
               else
                  k = 1'b0;
            end
            // Complement AND to carry, bit and carry complement.
            4'hB: begin
               if (op[3:0] == 4'h0)
                  t = `CIT_T_BIT_LOGIC;
               else if (op[3:0] == 4'h2)
                  t = `CIT_T_BIT_WRITE;
               else if (op[3:0] == 4'h3)
                  t = `CIT_T_CARRY;
               else
                  k = 1'b0;
            end
            // Push, bit clear, nibble swap and exchanges.
            4'hC: begin
               if (lc == LC_REG)
                  t = `CIT_T_XCH_RN;
               else if (lc == LC_IND)
                  t = `CIT_T_XCH_IND;
               else if (op[3:0] == 4'h0)
                  t = `CIT_T_PUSH;
               else if (op[3:0] == 4'h2)
                  t = `CIT_T_BIT_WRITE;
               else if (op[3:0] == 4'h3)
                  t = `CIT_T_CARRY;
               else if (op[3:0] == 4'h4)
                  t = `CIT_T_ROT;
               else if (op[3:0] == 4'h5)
                  t = `CIT_T_XCH_DIR;
               else
                  k = 1'b0;
            end
            // Pop, bit set, decimal adjust and digit exchange.
            4'hD: begin
               if (lc == LC_IND)
                  t = `CIT_T_XCHD;
               else if (op[3:0] == 4'h0)
                  t = `CIT_T_POP;
               else if (op[3:0] == 4'h2)
                  t = `CIT_T_BIT_WRITE;
               else if (op[3:0] == 4'h3)
                  t = `CIT_T_CARRY;
               else if (op[3:0] == 4'h4)
                  t = `CIT_T_DA;
               else
                  k = 1'b0;
            end
            // Loads into the accumulator and accumulator clear.
            4'hE: begin
               if (lc == LC_REG)
                  t = `CIT_T_MOV_A_RN;
               else if (lc == LC_IND)
                  t = `CIT_T_MOV_A_IND;
               else if (op[3:0] == 4'h4)
                  t = `CIT_T_CLR_A;
               else if (op[3:0] == 4'h5)
                  t = `CIT_T_MOV_A_DIR;
               else
                  k = 1'b0;
            end
            // Stores from the accumulator and accumulator complement.
            4'hF: begin
               if (lc == LC_REG)
                  t = `CIT_T_MOV_RN_A;
               else if (lc == LC_IND)
                  t = `CIT_T_MOV_IND_A;
               else if (op[3:0] == 4'h4)
                  t = `CIT_T_CPL_A;
               else if (op[3:0] == 4'h5)
                  t = `CIT_T_MOV_DIR_A;
               else
                  k = 1'b0;
            end
            default: k = 1'b0;
         endcase
         if (!k)
            t = `CIT_T_UNKNOWN;
         cit_decode = {k, t};
      end
   endfunction

   reg              state;
   reg        [1:0] bytes_left;
   reg        [1:0] cur_len;
   reg        [2:0] cur_cyc;
   reg              cur_known;
   reg        [7:0] cur_op;
   reg        [7:0] cur_op1;
   reg        [7:0] cur_op2;
   wire [CYC_W-1:0] cyc_count;
   wire             take;
   wire       [5:0] dec;
   wire       [1:0] dec_len;
   wire       [2:0] dec_cyc;
   wire       [1:0] next_left;
   wire             exec_end;

   // Byte acceptance and decode of the byte on the bus.
   assign take      = code_req & code_valid;
   assign dec       = cit_decode(code_byte);
   assign dec_len   = dec[`CIT_LEN_MSB:`CIT_LEN_LSB];
   assign dec_cyc   = dec[`CIT_CYC_MSB:`CIT_CYC_LSB];
   assign next_left = bytes_left - {1'b0, take};

   // An instruction ends once all bytes are in and its last cycle is used.
   assign exec_end  = (next_left == 2'h0) &&
                      (cyc_count >= {{(CYC_W-3){1'b0}}, (cur_cyc - CYC_ONE)});

   // Counts system clocks from the opcode fetch onward.
   cit_cycle_ctr #(
      .W     (CYC_W)
   ) u_ctr (
      .clk   (clk),
      .rst_n (rst_n),
      .start ((state == ST_FETCH) & take),
      .step  (state == ST_EXEC),
      .count (cyc_count)
   );

   // Fetch and execution sequencer; results publish with the done pulse.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state      <= ST_FETCH;
         code_req   <= 1'b1;
         busy       <= 1'b0;
         ins_done   <= 1'b0;
         ins_opcode <= 8'h00;
         ins_op1    <= 8'h00;
         ins_op2    <= 8'h00;
         ins_len    <= 2'h0;
         ins_cyc    <= 3'h0;
         ins_known  <= 1'b0;
         bytes_left <= 2'h0;
         cur_len    <= 2'h0;
         cur_cyc    <= 3'h0;
         cur_known  <= 1'b0;
         cur_op     <= 8'h00;
         cur_op1    <= 8'h00;
         cur_op2    <= 8'h00;
      end else begin
         ins_done <= 1'b0;
         case (state)
            ST_FETCH: begin
               if (take) begin
                  cur_op    <= code_byte;
                  cur_len   <= dec_len;
                  cur_cyc   <= dec_cyc;
                  cur_known <= dec[5];
                  cur_op1   <= 8'h00;
                  cur_op2   <= 8'h00;
                  if ((dec_len == LEN_ONE) && (dec_cyc == CYC_ONE)) begin
                     // Single cycle forms finish on the opcode fetch itself.
                     ins_done   <= 1'b1;
                     ins_opcode <= code_byte;
                     ins_op1    <= 8'h00;
                     ins_op2    <= 8'h00;
                     ins_len    <= dec_len;
                     ins_cyc    <= dec_cyc;
                     ins_known  <= dec[5];
                  end else begin
                     state      <= ST_EXEC;
                     busy       <= 1'b1;
                     bytes_left <= dec_len - LEN_ONE;
                     code_req   <= (dec_len != LEN_ONE);
                  end
               end
            end
            ST_EXEC: begin
               if (take) begin
                  // The operand index follows from the bytes still owed.
                  if (bytes_left == (cur_len - LEN_ONE))
                     cur_op1 <= code_byte;
                  else
                     cur_op2 <= code_byte;
               end
               bytes_left <= next_left;
               if (exec_end) begin
                  state      <= ST_FETCH;
                  busy       <= 1'b0;
                  code_req   <= 1'b1;
                  ins_done   <= 1'b1;
                  ins_opcode <= cur_op;
                  ins_op1    <= (take && (bytes_left == (cur_len - LEN_ONE))) ?
                                code_byte : cur_op1;
                  ins_op2    <= (take && (bytes_left != (cur_len - LEN_ONE))) ?
                                code_byte : cur_op2;
                  ins_len    <= cur_len;
                  ins_cyc    <= cur_cyc;
                  ins_known  <= cur_known;
               end else begin
                  code_req   <= (next_left != 2'h0);
               end
            end
            default: begin
               state    <= ST_FETCH;
               code_req <= 1'b1;
               busy     <= 1'b0;
            end
         endcase
      end
   end

endmodule // cit_timing_core

// ===== verification/cit_timing_chk.sv
// Assertion checker for the instruction timing unit, bound to its top module.
`timescale 1ns/100ps
module cit_timing_chk #(
   parameter CYC_W = 3                    // Width of the cycle counter.
) (
   input wire       clk,                  // System clock.
   input wire       rst_n,                // Asynchronous reset, active low.
   input wire [7:0] code_byte,            // Byte from program memory.
   input wire       code_valid,           // Program memory byte is present.
   input wire       code_req,             // Unit will take a byte.
   input wire       busy,                 // Instruction in progress.
   input wire       ins_done,             // Completion pulse.
   input wire [7:0] ins_opcode,           // Completed opcode.
   input wire [7:0] ins_op1,              // First operand.
   input wire [7:0] ins_op2,              // Second operand.
   input wire [1:0] ins_len,              // Bytes fetched.
   input wire [2:0] ins_cyc,              // Cycle count from its timing.
   input wire       ins_known             // Opcode had a known timing.
);
   reg  [2:0] takes;
   reg  [3:0] el;
   wire       take = code_req && code_valid;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Counts bytes taken and edges spent on the instruction now in flight.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         takes <= 3'h0;
         el    <= 4'h0;
      end else begin
         takes <= (ins_done ? 3'h0 : takes) + {2'h0, take};
         if (ins_done || takes == 3'h0) begin
            el <= take ? 4'h1 : 4'h0;
         end else if (el != 4'hF) begin
            el <= el + 4'h1;
         end
      end
   end

   chk_len_takes: assert property (ins_done |-> {1'b0, ins_len} == takes)
      else $error("instruction length differs from bytes taken");
   chk_cyc_floor: assert property (ins_done |-> {1'b0, ins_cyc} <= el)
      else $error("instruction finished sooner than its cycle count");
   chk_rot_single: assert property (ins_done && ins_opcode inside {8'h03, 8'h13, 8'h23,
      8'h33, 8'hC4} |-> ins_len == 2'h1 && ins_cyc == 3'h1)
      else $error("rotate or swap not one byte one cycle");
   chk_pair_zero: assert property (ins_done && ins_len == 2'h1 |->
      ins_op1 == 8'h00 && ins_op2 == 8'h00) else $error("missing operands not zero");
   chk_hold_data: assert property ($changed(ins_opcode) || $changed(ins_len)
      || $changed(ins_cyc) |-> ins_done) else $error("result changed without completion");
   chk_done_req: assert property (ins_done |-> code_req && !busy)
      else $error("completion without request ready");
   chk_idle_req: assert property (!code_req |-> busy)
      else $error("request withheld while idle");
   chk_dptr_load: assert property (ins_done && ins_opcode == 8'h90 |->
      ins_len == 2'h3 && ins_cyc == 3'h3) else $error("pointer load timing wrong");
   chk_push_time: assert property (ins_done && ins_opcode == 8'hC0 |->
      ins_len == 2'h2 && ins_cyc == 3'h4) else $error("push timing wrong");
endmodule // cit_timing_chk

bind cit_timing_core cit_timing_chk #(.CYC_W(CYC_W)) u_cit_timing_chk (.clk, .rst_n, .code_byte,
   .code_valid, .code_req, .busy, .ins_done, .ins_opcode, .ins_op1, .ins_op2, .ins_len,
   .ins_cyc, .ins_known);

// ===== verification/cit_mem_model.sv
// Program memory model that hands code bytes to the timing unit.
`timescale 1ns/100ps
module cit_mem_model (
   input  wire       clk,                 // System clock.
   input  wire       rst_n,               // Asynchronous reset, active low.
   input  wire       slow,                // Offer a new byte only every other cycle.
   input  wire [7:0] nbytes,              // Number of bytes in the program.
   input  wire       code_req,            // Unit will take a byte.
   output reg        code_valid,          // Byte on code_byte is valid.
   output reg  [7:0] code_byte            // Bytes in program order.
);
   reg  [7:0] mem [0:255];
   reg  [7:0] ptr;
   reg        phase;
   reg        held;
   wire       offer = (ptr < nbytes) && (!slow || phase || held);

   // Starts quiet so the unit sees defined inputs from time zero.
   initial begin
      code_valid = 1'b0;
      code_byte  = 8'h00;
      phase      = 1'b0;
      ptr        = 8'h00;
      held       = 1'b0;
   end

   // Moves on only when a byte is taken; a refused byte stays offered until taken.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ptr  <= 8'h00;
         held <= 1'b0;
      end else begin
         held <= code_valid && !code_req;
         if (code_req && code_valid) begin
            ptr <= ptr + 8'h01;
         end
      end
   end

   // Changes after the falling edge; an idle line shows the inverse of its last value.
   always @(negedge clk) begin
      phase      <= ~phase;
      code_valid <= offer;
      code_byte  <= offer ? mem[ptr] : ~code_byte;
   end
endmodule // cit_mem_model

// ===== verification/test_cit_timing_core.sv
// Self-checking testbench for the instruction timing unit.
`timescale 1ns/100ps
module test_cit_timing_core;
   localparam NT = 79;
   reg          clk = 1'b0;
   reg          rst_n = 1'b0;
   reg          slow = 1'b0;
   reg  [7:0]   nbytes = 8'h00;
   wire [7:0]   code_byte, ins_opcode, ins_op1, ins_op2;
   wire         code_valid, code_req, busy, ins_done, ins_known;
   wire [1:0]   ins_len;
   wire [2:0]   ins_cyc;
   int          num_errors = 0;
   int          tests_run = 0;
   int          gap = -1;
   bit          fast = 1'b1;
   int          exp_q[$];
   logic [15:0] tbl [0:NT-1] = '{16'hE811, 16'hE522, 16'hE612, 16'h7422,
      16'hF812, 16'hA824, 16'h7822, 16'hF523, 16'h8823, 16'h8534, 16'h8624,
      16'h7533, 16'hF613, 16'hA623, 16'h7623, 16'h9033, 16'h9314, 16'h8314,
      16'hC024, 16'hD023, 16'hC813, 16'hC524, 16'hC614, 16'hD614,
      16'h2812, 16'h2523, 16'h2613, 16'h2422, 16'h3812, 16'h3523, 16'h3613, 16'h3422,
      16'h9812, 16'h9523, 16'h9613, 16'h9422, 16'h5812, 16'h5523, 16'h5613, 16'h5422,
      16'h5224, 16'h5334, 16'h4812, 16'h4523, 16'h4613, 16'h4422, 16'h4224, 16'h4334,
      16'h6812, 16'h6523, 16'h6613, 16'h6422, 16'h6224, 16'h6334,
      16'h2311, 16'h3311, 16'h0311, 16'h1311, 16'hC411,
      16'h8223, 16'hB023, 16'h7223, 16'hA023, 16'hA223, 16'h9224, 16'h0011, 16'hE011,
      16'h0412, 16'h0813, 16'h1524, 16'h1614, 16'hA311, 16'hA414, 16'h8415, 16'hD414,
      16'hE411, 16'hF412, 16'hC311, 16'hD224};

   cit_timing_core #(.CYC_W(3)) u_cit_timing_core (.clk(clk), .rst_n(rst_n),
      .code_byte(code_byte), .code_valid(code_valid), .code_req(code_req), .busy(busy),
      .ins_done(ins_done), .ins_opcode(ins_opcode), .ins_op1(ins_op1), .ins_op2(ins_op2),
      .ins_len(ins_len), .ins_cyc(ins_cyc), .ins_known(ins_known));
   cit_mem_model u_cit_mem_model (.clk(clk), .rst_n(rst_n), .slow(slow), .nbytes(nbytes),
      .code_req(code_req), .code_valid(code_valid), .code_byte(code_byte));

   // Free-running clock of 8 ns period.
   always #4 clk = ~clk;

   task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic close_out;
      $display("Comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic check_done;
      int          i;
      logic [15:0] e;
      logic [7:0]  idx;
      if (exp_q.size() == 0) begin
         cmp("spare_done", 8'h00, 8'h01);
      end else begin
         i = exp_q.pop_front();
         e = tbl[i];
         idx = i[7:0];
         cmp("opcode", e[15:8], ins_opcode);
         cmp("len", {4'h0, e[7:4]}, {6'h00, ins_len});
         cmp("cyc", {4'h0, e[3:0]}, {5'h00, ins_cyc});
         cmp("known", {7'h00, e[15:8] != 8'h00 && e[15:8] != 8'hE0}, {7'h00, ins_known});
         cmp("op1", e[7:4] > 4'h1 ? idx : 8'h00, ins_op1);
         cmp("op2", e[7:4] > 4'h2 ? ~idx : 8'h00, ins_op2);
         if (fast) cmp("gap", {4'h0, e[3:0]}, gap[7:0]);
      end
   endtask

   // Judges each completion; in the fast run, edges since the previous one give the cycle count.
   always @(posedge clk) begin
      if (!rst_n) begin
         gap = -1;
      end else begin
         gap++;
         if (ins_done === 1'b1) begin
            check_done();
            gap = 0;
         end
      end
   end

   // Loads the whole table as one program while reset is held, then releases it.
   task automatic start(input bit slow_mode);
      int k;
      k = 0;
      @(negedge clk);
      rst_n = 1'b0;
      exp_q.delete();
      for (int i = 0; i < NT; i++) begin
         u_cit_mem_model.mem[k] = tbl[i][15:8];
         k++;
         if (tbl[i][7:4] > 4'h1) u_cit_mem_model.mem[k] = i[7:0];
         if (tbl[i][7:4] > 4'h1) k++;
         if (tbl[i][7:4] > 4'h2) u_cit_mem_model.mem[k] = ~i[7:0];
         if (tbl[i][7:4] > 4'h2) k++;
         exp_q.push_back(i);
      end
      nbytes = k[7:0];
      slow = slow_mode;
      fast = !slow_mode;
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
   endtask

   task automatic drain;
      int left;
      for (int n = 0; n < 3000 && exp_q.size() > 0; n++) @(posedge clk);
      repeat (4) @(negedge clk);
      left = exp_q.size();
      cmp("left_over", 8'h00, left[7:0]);
   endtask

   // Every timed form back to back with memory answering at once.
   task automatic run_all_fast;
      start(1'b0);
      drain();
   endtask

   // Stalling memory, a reset in mid-instruction, then a full slow run.
   task automatic run_slow_with_reset;
      start(1'b1);
      repeat (9) @(negedge clk);
      rst_n = 1'b0;
      @(negedge clk);
      cmp("req_in_reset", 8'h01, {7'h00, code_req});
      cmp("busy_in_reset", 8'h00, {7'h00, busy});
      cmp("done_in_reset", 8'h00, {7'h00, ins_done});
      start(1'b1);
      drain();
   endtask

   // Main sequence.
   initial begin
      run_all_fast();
      run_slow_with_reset();
      close_out();
   end

   // Watchdog against a hang.
   initial begin
      repeat (10000) @(posedge clk);
      num_errors++;
      $display("Error watchdog expected finish seen timeout");
      close_out();
   end
endmodule // test_cit_timing_core
